// ---- asds_diag_sequencer.v ----
// Service diagnostic sequencer of the appliance main control
// Summary of operation
// RL1: Entry only when powered on and cooling
// RL2: Both keys held 3 s enter, beep
// RL3: Filter key alone 2 s advances, beep
// RL4: Leave diagnostics after 20 minutes
// RL5: Show step number and result code
// RL6: Steps 1,2 thermistors: 01/02/03 codes
// RL7: Step 3 fan 2500 rpm, 01/02
// RL8: Step 4 condenser fan on, 01
// RL9: Step 5 compressor 4500 rpm, 01/02
// RL10: Step 6 damper opens fully, 01
// RL11: Step 7 heater on, bimetal 01/02
// RL12: Advance at step 7 ends diagnostics
// RL13: Key hold counter restarts on key release
`timescale 1ns/1ps
`default_nettype none
`include "asds_defs.vh"
module asds_diag_sequencer #(
    parameter ENTRY_MS     = `ASDS_ENTRY_MS,
    parameter ADVANCE_MS   = `ASDS_ADVANCE_MS,
    parameter TIMEOUT_MS   = `ASDS_TIMEOUT_MS,
    parameter COMP_WAIT_MS = `ASDS_COMP_START_MS,
    parameter BEEP_MS      = `ASDS_BEEP_MS,
    parameter TICK_CYCLES  = `ASDS_TICK_CYCLES
) (
    input  wire        core_clk,          // 40 MHz system clock
    input  wire        resetn,            // Async reset, active low
    input  wire        powerOn,           // Control switched on
    input  wire        normalCooling,     // Control in normal cooling mode
    input  wire        filterResetKey,    // Filter reset key pressed, pin
    input  wire        powerKey,          // Power key pressed, pin
    input  wire        frzThermOpen,      // Freezer thermistor reads open
    input  wire        frzThermShort,     // Freezer thermistor reads shorted
    input  wire        refThermOpen,      // Compartment thermistor reads open
    input  wire        refThermShort,     // Compartment thermistor reads shorted
    input  wire [15:0] evapFanRpm,        // Evaporator fan speed feedback
    input  wire [15:0] compRpm,           // Compressor speed feedback
    input  wire        bimetalClosed,     // Bimetal input, pin
    output reg         diagActive,        // Diagnostics running
    output reg  [3:0]  stepNumber,        // Step on compartment display
    output reg  [7:0]  filterStatusCode,  // Result on filter status indicator
    output reg         beep,              // Buzzer drive
    output reg  [15:0] evapFanCmdRpm,     // Evaporator fan speed command
    output reg         condFanOn,         // Condenser fan output
    output reg  [15:0] compCmdRpm,        // Compressor speed command
    output reg         damperOpen,        // Drive air damper toward open
    output reg         defrostHeaterOn    // Defrost heater output
);
    localparam ST_IDLE = 1'b0;
    localparam ST_DIAG = 1'b1;

    // Two-flop synchronisers for pin inputs
    reg [1:0] fkSync;
    reg [1:0] pkSync;
    reg [1:0] bmSync;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fkSync <= 2'b00;
            pkSync <= 2'b00;
            bmSync <= 2'b00;
        end else begin
            fkSync <= {fkSync[0], filterResetKey};
            pkSync <= {pkSync[0], powerKey};
            bmSync <= {bmSync[0], bimetalClosed};
        end
    end
    wire fKey = fkSync[1];
    wire pKey = pkSync[1];
    wire bmClosed = bmSync[1];

    reg        stateReg;
    reg        keyDoneReg;     // Hold already acted on until release
    reg        compWaitDone;
    wire       keyCombo;
    wire [31:0] keyMs;
    wire [31:0] diagMs;
    wire [31:0] beepMs;
    wire [31:0] stepMs;
    wire       msTick;

    // Entry combo when idle, filter key alone when in diagnostics
    assign keyCombo = (stateReg == ST_IDLE) ? (fKey && pKey) : (fKey && !pKey);

    // Key hold timer restarts on release of the combination [RL13]
    asds_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) keyTimer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .restart  (!keyCombo),      // [RL13]
        .msCount  (keyMs),
        .tick     (msTick)
    );
    // Diagnostics timeout timer, restarts while idle [RL4]
    asds_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) diagTimer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .restart  (stateReg == ST_IDLE),
        .msCount  (diagMs),
        .tick     ()
    );
    // Beep length timer
    asds_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) beepTimer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .restart  (!beep),
        .msCount  (beepMs),
        .tick     ()
    );
    // Time spent in the current step
    reg stepRestart;
    asds_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) stepTimer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .restart  (stepRestart),
        .msCount  (stepMs),
        .tick     ()
    );

    wire enterReq  = (stateReg == ST_IDLE) && powerOn && normalCooling && keyCombo && !keyDoneReg
                     && (keyMs >= ENTRY_MS);                                   // [RL1] [RL2]
    wire advReq    = (stateReg == ST_DIAG) && keyCombo && !keyDoneReg && (keyMs >= ADVANCE_MS); // [RL3]
    wire timeout   = (stateReg == ST_DIAG) && (diagMs >= TIMEOUT_MS);          // [RL4]
    wire exitReq   = timeout || (advReq && stepNumber == `ASDS_LAST_STEP) || !powerOn; // [RL12]

    // Sequencer state, step and beep
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stateReg    <= ST_IDLE;
            stepNumber  <= 4'h0;
            keyDoneReg  <= 1'b0;
            beep        <= 1'b0;
            stepRestart <= 1'b1;
        end else begin
            stepRestart <= 1'b0;
            if (!keyCombo)
                keyDoneReg <= 1'b0;
            if (beep && beepMs >= BEEP_MS)
                beep <= 1'b0;
            case (stateReg)
                ST_IDLE: begin
                    if (enterReq) begin
                        stateReg    <= ST_DIAG;                        // [RL2]
                        stepNumber  <= 4'h1;
                        keyDoneReg  <= 1'b1;
                        beep        <= 1'b1;                           // [RL2]
                        stepRestart <= 1'b1;
                    end
                end
                ST_DIAG: begin
                    if (exitReq) begin
                        stateReg   <= ST_IDLE;                         // [RL4] [RL12]
                        stepNumber <= 4'h0;
                        if (advReq) begin
                            keyDoneReg <= 1'b1;
                            beep       <= 1'b1;
                        end
                    end else if (advReq) begin
                        stepNumber  <= stepNumber + 4'h1;              // [RL3]
                        keyDoneReg  <= 1'b1;
                        beep        <= 1'b1;                           // [RL3]
                        stepRestart <= 1'b1;
                    end
                end
                default: stateReg <= ST_IDLE;
            endcase
        end
    end

    // Result code for each thermistor step
    function [7:0] thermCode;
        input isOpen;
        input isShort;
        begin
            if (isOpen)
                thermCode = `ASDS_CODE_02;
            else if (isShort)
                thermCode = `ASDS_CODE_03;
            else
                thermCode = `ASDS_CODE_01;
        end
    endfunction

    // Loads and display for the current step
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            diagActive       <= 1'b0;
            filterStatusCode <= `ASDS_CODE_NONE;
            evapFanCmdRpm    <= 16'h0;
            condFanOn        <= 1'b0;
            compCmdRpm       <= 16'h0;
            damperOpen       <= 1'b0;
            defrostHeaterOn  <= 1'b0;
            compWaitDone     <= 1'b0;
        end else begin
            diagActive       <= (stateReg == ST_DIAG);                 // [RL5]
            evapFanCmdRpm    <= 16'h0;
            condFanOn        <= 1'b0;
            compCmdRpm       <= 16'h0;
            damperOpen       <= 1'b0;
            defrostHeaterOn  <= 1'b0;
            filterStatusCode <= `ASDS_CODE_NONE;
            compWaitDone     <= (stepNumber == 4'h5) && !stepRestart && (stepMs >= COMP_WAIT_MS); // Fresh per step
            if (stateReg == ST_DIAG && !exitReq) begin                 // [RL12]
                case (stepNumber)
                    4'h1: filterStatusCode <= thermCode(frzThermOpen, frzThermShort); // [RL6]
                    4'h2: filterStatusCode <= thermCode(refThermOpen, refThermShort); // [RL6]
                    4'h3: begin
                        evapFanCmdRpm    <= `ASDS_EVAP_RPM;            // [RL7]
                        filterStatusCode <= (evapFanRpm >= `ASDS_EVAP_RPM) ? `ASDS_CODE_01 : `ASDS_CODE_02;
                    end
                    4'h4: begin
                        condFanOn        <= 1'b1;                      // [RL8]
                        filterStatusCode <= `ASDS_CODE_01;
                    end
                    4'h5: begin
                        compCmdRpm       <= `ASDS_COMP_RPM;            // [RL9]
                        if (compRpm >= `ASDS_COMP_RPM)
                            filterStatusCode <= `ASDS_CODE_01;
                        else if (compWaitDone)
                            filterStatusCode <= `ASDS_CODE_02;         // [RL9]
                    end
                    4'h6: begin
                        damperOpen       <= 1'b1;                      // [RL10]
                        filterStatusCode <= `ASDS_CODE_01;
                    end
                    4'h7: begin
                        defrostHeaterOn  <= 1'b1;                      // [RL11]
                        filterStatusCode <= bmClosed ? `ASDS_CODE_01 : `ASDS_CODE_02;
                    end
                    default: filterStatusCode <= `ASDS_CODE_NONE;
                endcase
            end
        end
    end
endmodule // asds_diag_sequencer
`default_nettype wire

// ---- asds_defs.vh ----
// Constants for the service diagnostic sequencer
`ifndef ASDS_DEFS_VH
`define ASDS_DEFS_VH
`define ASDS_CLK_HZ          40000000
`define ASDS_TICK_MS         1
`define ASDS_TICK_CYCLES     ((`ASDS_CLK_HZ / 1000) * `ASDS_TICK_MS)
`define ASDS_ENTRY_MS        3000
`define ASDS_ADVANCE_MS      2000
`define ASDS_TIMEOUT_MIN     20
`define ASDS_TIMEOUT_MS      (`ASDS_TIMEOUT_MIN * 60 * 1000)
`define ASDS_COMP_START_S    7
`define ASDS_COMP_START_MS   (`ASDS_COMP_START_S * 1000)
`define ASDS_EVAP_RPM        16'd2500
`define ASDS_COMP_RPM        16'd4500
`define ASDS_BEEP_MS         100
`define ASDS_CODE_NONE       8'h00
`define ASDS_CODE_01         8'h01
`define ASDS_CODE_02         8'h02
`define ASDS_CODE_03         8'h03
`define ASDS_LAST_STEP       4'h7
`endif

// ---- asds_tick_timer.v ----
// Millisecond tick generator and resettable millisecond counter
`timescale 1ns/1ps
`default_nettype none
`include "asds_defs.vh"
module asds_tick_timer #(
    parameter TICK_CYCLES = `ASDS_TICK_CYCLES
) (
    input  wire        core_clk,   // System clock
    input  wire        resetn,     // Async reset, active low
    input  wire        restart,    // Clears the count
    output reg  [31:0] msCount,    // Elapsed milliseconds
    output wire        tick        // One-cycle millisecond pulse
);
    reg [31:0] divReg;

    assign tick = (divReg == TICK_CYCLES - 1);

    // Divider and tick-driven counter
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            divReg  <= 32'h0;
            msCount <= 32'h0;
        end else begin
            divReg <= tick ? 32'h0 : divReg + 32'h1;
            if (restart)
                msCount <= 32'h0;
            else if (tick && msCount != 32'hffffffff)
                msCount <= msCount + 32'h1;
        end
    end
endmodule // asds_tick_timer
`default_nettype wire

// ---- asds_diag_chk.sv ----
// Assertion checker for the service diagnostic sequencer
`timescale 1ns/1ps
`default_nettype none
module asds_diag_chk (
    input wire logic        core_clk,         // Clock
    input wire logic        resetn,           // Reset, active low
    input wire logic        powerOn,          // Control on
    input wire logic        normalCooling,    // Cooling mode
    input wire logic        diagActive,       // In diagnostics
    input wire logic [3:0]  stepNumber,       // Step shown
    input wire logic [7:0]  filterStatusCode, // Result code
    input wire logic        beep,             // Buzzer
    input wire logic [15:0] evapFanCmdRpm,    // Fan command
    input wire logic        condFanOn,        // Condenser fan
    input wire logic [15:0] compCmdRpm,       // Compressor command
    input wire logic        damperOpen,       // Damper drive
    input wire logic        defrostHeaterOn   // Heater
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Entry and stepping
    entry_gate_a: assert property ($past(stepNumber) == 4'h0 && stepNumber == 4'h1
        |-> $past(normalCooling) && $past(powerOn))
        else $error("entry outside cooling mode");
    power_off_exit_a: assert property (!powerOn && stepNumber != 4'h0 |=> stepNumber == 4'h0)
        else $error("diagnostics kept after power off");
    step_beep_a: assert property (stepNumber != 4'h0 && $past(stepNumber) != stepNumber |-> beep)
        else $error("step change without beep");
    step_order_a: assert property (stepNumber != 4'h0 && $past(stepNumber) != stepNumber |-> stepNumber == $past(stepNumber) + 4'h1)
        else $error("step skipped");
    active_flag_a: assert property (stepNumber != 4'h0 |=> diagActive)
        else $error("active flag missing");
    // Loads follow their steps
    evap_cmd_a: assert property (stepNumber == 4'h3 && $past(stepNumber) == 4'h3 |-> evapFanCmdRpm == 16'h09c4)
        else $error("fan command wrong");
    cond_fan_a: assert property (stepNumber == 4'h4 && $past(stepNumber) == 4'h4 |-> condFanOn && filterStatusCode == 8'h01)
        else $error("condenser step wrong");
    comp_cmd_a: assert property (stepNumber == 4'h5 && $past(stepNumber) == 4'h5 |-> compCmdRpm == 16'h1194)
        else $error("compressor command wrong");
    damper_open_a: assert property (stepNumber == 4'h6 && $past(stepNumber) == 4'h6 |-> damperOpen && filterStatusCode == 8'h01)
        else $error("damper step wrong");
    heater_on_a: assert property (stepNumber == 4'h7 && $past(stepNumber) == 4'h7 |-> defrostHeaterOn)
        else $error("heater off in step seven");
    idle_quiet_a: assert property (stepNumber == 4'h0 && $past(stepNumber) == 4'h0 |-> !condFanOn && !damperOpen
        && !defrostHeaterOn && evapFanCmdRpm == 16'h0000 && compCmdRpm == 16'h0000 && filterStatusCode == 8'h00)
        else $error("load active outside diagnostics");
endmodule // asds_diag_chk
bind asds_diag_sequencer asds_diag_chk chk (.core_clk(core_clk), .resetn(resetn), .powerOn(powerOn),
    .normalCooling(normalCooling), .diagActive(diagActive), .stepNumber(stepNumber),
    .filterStatusCode(filterStatusCode), .beep(beep), .evapFanCmdRpm(evapFanCmdRpm), .condFanOn(condFanOn),
    .compCmdRpm(compCmdRpm), .damperOpen(damperOpen), .defrostHeaterOn(defrostHeaterOn));
`default_nettype wire

// ---- asds_appliance_model.sv ----
// Model of the fan and compressor speed feedback
`timescale 1ns/1ps
`default_nettype none
module asds_appliance_model (
    input  wire logic        core_clk,      // Clock
    input  wire logic        resetn,        // Reset, active low
    input  wire logic [15:0] evapFanCmdRpm, // Fan command
    input  wire logic [15:0] compCmdRpm,    // Compressor command
    input  wire logic        fanWeak,       // Fan runs short
    input  wire logic        compDead,      // Compressor never starts
    output var  logic [15:0] evapFanRpm,    // Fan feedback
    output var  logic [15:0] compRpm        // Compressor feedback
);
    logic [3:0] spinUp_reg;
    // Fan tracks its command; compressor starts after a short spin-up
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            evapFanRpm <= 16'h0000;
            compRpm <= 16'h0000;
            spinUp_reg <= 4'h0;
        end else begin
            evapFanRpm <= (fanWeak && evapFanCmdRpm != 16'h0000) ? evapFanCmdRpm - 16'h0064 : evapFanCmdRpm;
            spinUp_reg <= (compCmdRpm == 16'h0000) ? 4'h0 : spinUp_reg + {3'h0, spinUp_reg != 4'hf};
            compRpm <= (spinUp_reg == 4'hf && !compDead) ? compCmdRpm : 16'h0000;
        end
    end
endmodule // asds_appliance_model
`default_nettype wire

// ---- asds_diag_sequencer_tb.sv ----
// Testbench for the service diagnostic sequencer
`timescale 1ns/1ps
`default_nettype none
module asds_diag_sequencer_tb;
    localparam int TK = 4;
    localparam int EN = 6;
    localparam int AD = 4;
    localparam int TO = 300;
    localparam int CW = 5;
    logic core_clk = 1'b0, resetn = 1'b0, powerOn = 1'b1, normalCooling = 1'b1;
    logic filterResetKey = 1'b0, powerKey = 1'b0, bimetalClosed = 1'b0, fanWeak = 1'b0, compDead = 1'b0;
    logic frzThermOpen = 1'b0, frzThermShort = 1'b0, refThermOpen = 1'b0, refThermShort = 1'b0;
    logic [15:0] evapFanRpm, compRpm, evapFanCmdRpm, compCmdRpm;
    logic [7:0]  filterStatusCode;
    logic [3:0]  stepNumber;
    logic        diagActive, beep, condFanOn, damperOpen, defrostHeaterOn;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    always #12.5 core_clk = ~core_clk;
    asds_diag_sequencer #(.ENTRY_MS(EN), .ADVANCE_MS(AD), .TIMEOUT_MS(TO), .COMP_WAIT_MS(CW), .BEEP_MS(3),
        .TICK_CYCLES(TK)) dut (.core_clk(core_clk), .resetn(resetn), .powerOn(powerOn),
        .normalCooling(normalCooling), .filterResetKey(filterResetKey), .powerKey(powerKey),
        .frzThermOpen(frzThermOpen), .frzThermShort(frzThermShort), .refThermOpen(refThermOpen),
        .refThermShort(refThermShort), .evapFanRpm(evapFanRpm), .compRpm(compRpm), .bimetalClosed(bimetalClosed),
        .diagActive(diagActive), .stepNumber(stepNumber), .filterStatusCode(filterStatusCode), .beep(beep),
        .evapFanCmdRpm(evapFanCmdRpm), .condFanOn(condFanOn), .compCmdRpm(compCmdRpm), .damperOpen(damperOpen),
        .defrostHeaterOn(defrostHeaterOn));
    asds_appliance_model far (.core_clk(core_clk), .resetn(resetn), .evapFanCmdRpm(evapFanCmdRpm),
        .compCmdRpm(compCmdRpm), .fanWeak(fanWeak), .compDead(compDead), .evapFanRpm(evapFanRpm), .compRpm(compRpm));
    // Compare and count
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Bounded wait for a step, aborts the run if it never comes
    task automatic wait_step(input logic [3:0] exp, input int lim, output int n);
        n = 0;
        while (stepNumber !== exp && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        if (stepNumber !== exp) begin
            check("step reached", {12'h000, exp}, {12'h000, stepNumber});
            test_done();
        end
    endtask
    // Filter key first, power key a cycle later, held until the step moves
    task automatic press(input logic p, input logic [3:0] exp, input int ms);
        int n;
        filterResetKey = 1'b1;
        @(negedge core_clk);
        powerKey = p;
        wait_step(exp, (ms + 4) * TK, n);
        check("hold time", 16'h0001, {15'h0000, n >= (ms - 1) * TK});
        check("beep", 16'h0001, {15'h0000, beep});
        filterResetKey = 1'b0;
        powerKey = 1'b0;
        repeat (3 * TK) @(negedge core_clk);
    endtask
    // Entry refused with cooling mode off or power off; gate restored only once keys are seen released
    task automatic t_refuse(input logic cool);
        normalCooling = cool;
        powerOn = !cool;
        filterResetKey = 1'b1;
        powerKey = 1'b1;
        repeat ((EN + 4) * TK) @(negedge core_clk);
        check("refused entry", 16'h0000, {12'h000, stepNumber});
        filterResetKey = 1'b0;
        powerKey = 1'b0;
        repeat (2 * TK) @(negedge core_clk);
        normalCooling = 1'b1;
        powerOn = 1'b1;
        repeat (2 * TK) @(negedge core_clk);
        check("no late entry", 16'h0000, {12'h000, stepNumber});
        $display("test refuse done");
    endtask
    // Power switched off in diagnostics ends the run at once
    task automatic t_power();
        press(1'b1, 4'h1, EN);
        powerOn = 1'b0;
        repeat (2) @(negedge core_clk);
        check("power exit", 16'h0000, {11'h000, diagActive, stepNumber});
        powerOn = 1'b1;
        repeat (2 * TK) @(negedge core_clk);
        $display("test power done");
    endtask
    // All seven steps, healthy loads or faulty ones
    task automatic t_run(input logic bad);
        logic [7:0] exp;
        logic [4:0] want;
        logic [4:0] ld;
        frzThermOpen = bad;
        refThermShort = bad;
        fanWeak = bad;
        compDead = bad;
        bimetalClosed = !bad;
        for (int s = 1; s <= 7; s++) begin
            press(s == 1, s[3:0], s == 1 ? EN : AD);
            repeat ((CW + 2) * TK) @(negedge core_clk);
            exp = (!bad || s == 4 || s == 6) ? 8'h01 : (s == 2) ? 8'h03 : 8'h02;
            check("step shown", s[15:0], {12'h000, stepNumber});
            check("result code", {8'h00, exp}, {8'h00, filterStatusCode});
            want = {s == 3, s == 4, s == 5, s == 6, s == 7};
            ld = {evapFanCmdRpm == 16'h09c4, condFanOn, compCmdRpm == 16'h1194, damperOpen, defrostHeaterOn};
            check("loads", {11'h000, want}, {11'h000, ld});
        end
        press(1'b0, 4'h0, AD);
        check("heater off", 16'h0000, {15'h0000, defrostHeaterOn});
        check("diag left", 16'h0000, {15'h0000, diagActive});
        $display("test run done");
    endtask
    task automatic t_timeout();
        int n;
        press(1'b1, 4'h1, EN);
        wait_step(4'h0, (TO + 5) * TK, n);
        check("timeout span", 16'h0001, {15'h0000, n >= (TO - 5) * TK});
        $display("test timeout done");
    endtask
    // Main sequence
    initial begin
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        repeat (2) @(negedge core_clk);
        check("reset state", 16'h0000, {11'h000, diagActive, beep, condFanOn, damperOpen, defrostHeaterOn});
        t_refuse(1'b0);
        t_refuse(1'b1);
        t_run(1'b0);
        t_run(1'b1);
        t_power();
        t_timeout();
        test_done();
    end
endmodule // asds_diag_sequencer_tb
`default_nettype wire
